// *** design/pgt_trigger_ctrl.sv ***
// Purpose: Start, stop, trigger delay, reload and auto-increment control of a pulse generator
// Assumes: Comparator events and trigger pin are asynchronous; single 200 MHz clock
// Notes:   Output polarity and hardware approach sequencing are outside this block
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "pgt_regs.svh"

module pgt_trigger_ctrl #(
    parameter int CNT_W = 9                              // Counter and preload width
) (
    input  wire logic        core_clk,                   // System clock, 200 MHz
    input  wire logic        rst_n,                      // Asynchronous reset, active low
    input  wire logic        wb_cyc_i,                   // Wishbone cycle
    input  wire logic        wb_stb_i,                   // Wishbone strobe
    input  wire logic        wb_we_i,                    // Wishbone write enable
    input  wire logic [7:0]  wb_adr_i,                   // Wishbone byte address
    input  wire logic [3:0]  wb_sel_i,                   // Wishbone byte selects
    input  wire logic [31:0] wb_dat_i,                   // Wishbone write data
    output logic      [31:0] wb_dat_o,                   // Wishbone read data
    output logic             wb_ack_o,                   // Wishbone acknowledge
    input  wire logic        trigger_input_pin,          // External trigger pin
    input  wire logic        comparator0_output,         // Comparator 0 output
    input  wire logic        comparator1_event,          // Comparator 1 event
    input  wire logic        comparator2_event,          // Comparator 2 event
    input  wire logic        comparator3_event,          // Comparator 3 event
    input  wire logic        retrigger_active,           // Retrigger timer activity pulse
    output logic             delayed_hw_trigger,         // Delayed hardware trigger pulse
    output logic             pulse_out,                  // Generator running pulse
    output logic             width_limit_hit             // Pulse width limit reached pulse
);

    // Field positions and the 9-bit arithmetic below are fixed
    if (CNT_W != 9) begin : g_width_check
        $error("pgt_trigger_ctrl: only CNT_W of 9 is supported");
    end

    pgt_pkg::pgt_state_t s_reg;
    pgt_pkg::pgt_state_t s_next;

    logic       wbReq;
    logic       wbWr;
    logic       rawSel;
    logic       rawFall;
    logic       qualEdge;
    logic       c1Fall;
    logic       c2Fall;
    logic       c3Fall;
    logic       c3Stops;
    logic       eventStop;
    logic       swSet;
    logic       swClr;
    logic       startReq;
    logic       cntTick;
    logic       dlyTick;
    logic [5:0] dlyCode;
    logic [7:0] wrByte;

    assign wbReq  = wb_cyc_i && wb_stb_i && !s_reg.ack;
    assign wbWr   = wbReq && wb_we_i && wb_sel_i[0];
    assign wrByte = wb_dat_i[7:0];

    always_comb begin
        s_next = s_reg;
        // ****************************************
        // Input synchronisers and edge detection
        // ****************************************
        s_next.pinSync = {s_reg.pinSync[0], trigger_input_pin};
        s_next.c0Sync  = {s_reg.c0Sync[0], comparator0_output};
        s_next.c1Sync  = {s_reg.c1Sync[0], comparator1_event};
        s_next.c2Sync  = {s_reg.c2Sync[0], comparator2_event};
        s_next.c3Sync  = {s_reg.c3Sync[0], comparator3_event};
        rawSel = s_reg.ctrl1[`PGT_C1_SRC] ? s_reg.c0Sync[1] : s_reg.pinSync[1];
        s_next.rawPrev = rawSel;
        s_next.c1Prev  = s_reg.c1Sync[1];
        s_next.c2Prev  = s_reg.c2Sync[1];
        s_next.c3Prev  = s_reg.c3Sync[1];
        rawFall = s_reg.rawPrev && !rawSel;
        c1Fall  = s_reg.c1Prev && !s_reg.c1Sync[1];
        c2Fall  = s_reg.c2Prev && !s_reg.c2Sync[1];
        c3Fall  = s_reg.c3Prev && !s_reg.c3Sync[1];
        c3Stops = c3Fall && !s_reg.valley;

        // ****************************************
        // Trigger qualification and delay
        // ****************************************
        qualEdge = 1'b0;
        if (rawFall && !s_reg.dlyActive) begin
            if (s_reg.ctrl0[`PGT_C0_EDGEMODE]) begin
                qualEdge       = s_reg.edgeArm;
                s_next.edgeArm = !s_reg.edgeArm;
            end else begin
                qualEdge = 1'b1;
            end
        end
        dlyCode = (s_reg.ctrl1[5:0] >= `PGT_DELAY_MAX) ? `PGT_DELAY_MAX : s_reg.ctrl1[5:0];
        s_next.dlyDiv = !s_reg.dlyDiv;
        dlyTick = !s_reg.ctrl1[`PGT_C1_DLYCLK] || s_reg.dlyDiv;
        s_next.hwTrig = 1'b0;
        if (qualEdge) begin
            if (dlyCode == 6'h00) begin
                s_next.hwTrig = 1'b1;
            end else begin
                s_next.dlyActive = 1'b1;
                s_next.dlyCnt    = dlyCode;
            end
        end else if (s_reg.dlyActive && dlyTick) begin
            if (s_reg.dlyCnt == 6'h01) begin
                s_next.dlyActive = 1'b0;
                s_next.hwTrig    = 1'b1;
            end
            s_next.dlyCnt = s_reg.dlyCnt - 6'h01;
        end

        // ****************************************
        // Register writes
        // ****************************************
        swSet = 1'b0;
        swClr = 1'b0;
        if (wbWr) begin
            if (wb_adr_i == `PGT_OFS_CTRL0) begin
                s_next.ctrl0 = wrByte;
                swSet = wrByte[`PGT_C0_SWTRIG];
                swClr = !wrByte[`PGT_C0_SWTRIG];
            end else if (wb_adr_i == `PGT_OFS_CTRL1) begin
                s_next.ctrl1 = wrByte;
            end else if (wb_adr_i == `PGT_OFS_INCR) begin
                s_next.incr = wrByte[4:0];
            end else if (wb_adr_i == `PGT_OFS_PRA) begin
                s_next.preA[7:0] = wrByte;
            end else if (wb_adr_i == `PGT_OFS_PRB) begin
                s_next.preB[7:0] = wrByte;
            end else if (wb_adr_i == `PGT_OFS_APC) begin
                s_next.apC[7:0] = wrByte;
            end else if (wb_adr_i == `PGT_OFS_APD) begin
                s_next.apD[7:0] = wrByte;
            end else if (wb_adr_i == `PGT_OFS_HIBITS) begin
                s_next.preA[8] = wrByte[`PGT_HI_A8];
                s_next.apC[8]  = wrByte[`PGT_HI_C8];
                s_next.preB[8] = wrByte[`PGT_HI_B8];
                s_next.apD[8]  = wrByte[`PGT_HI_D8];
            end else if (wb_adr_i == `PGT_OFS_LIMIT) begin
                s_next.limit = wrByte;
            end else if (wb_adr_i == `PGT_OFS_OPTS) begin
                s_next.valley = wrByte[`PGT_OPT_VALLEY];
            end
        end

        // Hardware sets and clears win over same-cycle software writes
        if (s_reg.ctrl0[`PGT_C0_ALTREL] && c1Fall) begin
            s_next.ctrl0[`PGT_C0_RELSEL] = 1'b1;
        end
        if (c2Fall || (c3Fall && !s_reg.valley)) begin
            s_next.ctrl0[`PGT_C0_RSTEN] = 1'b0;
        end

        // ****************************************
        // Automatic preload A increment
        // ****************************************
        if (!s_reg.c1Sync[1] && s_reg.incr[3:0] != 4'h0) begin
            if (s_reg.incFirst || s_reg.incTimer == 5'h01) begin
                s_next.preA = s_reg.preA + {5'h00, s_reg.incr[3:0]};
                s_next.incTimer = s_reg.incr[`PGT_INC_PERIOD] ? `PGT_INC_LONG : `PGT_INC_SHORT;
            end else begin
                s_next.incTimer = s_reg.incTimer - 5'h01;
            end
            s_next.incFirst = 1'b0;
        end else begin
            s_next.incFirst = 1'b1;
            s_next.incTimer = 5'h00;
        end

        // ****************************************
        // Run control and counter
        // ****************************************
        eventStop = s_reg.ctrl0[`PGT_C0_STOPEN] && (c2Fall || c3Stops);
        startReq  = swSet || (s_reg.ctrl0[`PGT_C0_RSTEN] && (s_reg.hwTrig || retrigger_active));
        s_next.cntDiv = !s_reg.cntDiv;
        cntTick = !s_reg.ctrl0[`PGT_C0_CNTCLK] || s_reg.cntDiv;
        s_next.pulse = s_reg.running;
        s_next.limitHalf = 1'b0;
        if (s_reg.running) begin
            if (swClr || eventStop || s_reg.limitCnt == 9'h000) begin
                s_next.running = 1'b0;
                s_next.ctrl0[`PGT_C0_SWTRIG] = 1'b0;
                s_next.limitHalf = (s_reg.limitCnt == 9'h000);
            end else if (cntTick) begin
                if (s_reg.counter == 9'h1FF) begin
                    s_next.running = 1'b0;
                    s_next.ctrl0[`PGT_C0_SWTRIG] = 1'b0;
                end
                s_next.counter = s_reg.counter + 9'h001;
                // Every second counter tick: the limit runs at half the counter clock in both modes
                s_next.limitCnt = s_reg.limitCnt - {8'h00, s_reg.counter[0]};
            end
        end else begin
            s_next.counter  = s_next.ctrl0[`PGT_C0_RELSEL] ? s_reg.preB : s_reg.preA;
            s_next.limitCnt = `PGT_LIMIT_BASE - {1'b0, s_reg.limit};
            if (startReq && !eventStop) begin
                s_next.running = 1'b1;
                s_next.ctrl0[`PGT_C0_SWTRIG] = 1'b1;
                // Synchronised start ticks on the next edge; unsynchronised start keeps the divider phase
                if (s_next.ctrl0[`PGT_C0_SYNC]) begin
                    s_next.cntDiv = 1'b1;
                end
            end
        end

        // ****************************************
        // Wishbone read path
        // ****************************************
        s_next.ack   = wbReq;
        s_next.rdata = 32'h0000_0000;
        if (wbReq && !wb_we_i) begin
            if (wb_adr_i == `PGT_OFS_CTRL0) begin
                s_next.rdata[7:0] = s_reg.ctrl0;
            end else if (wb_adr_i == `PGT_OFS_CTRL1) begin
                s_next.rdata[7:0] = s_reg.ctrl1;
            end else if (wb_adr_i == `PGT_OFS_INCR) begin
                s_next.rdata[7:0] = {`PGT_INC_UNIMP, s_reg.incr};
            end else if (wb_adr_i == `PGT_OFS_PRA) begin
                s_next.rdata[7:0] = s_reg.preA[7:0];
            end else if (wb_adr_i == `PGT_OFS_PRB) begin
                s_next.rdata[7:0] = s_reg.preB[7:0];
            end else if (wb_adr_i == `PGT_OFS_APC) begin
                s_next.rdata[7:0] = s_reg.apC[7:0];
            end else if (wb_adr_i == `PGT_OFS_APD) begin
                s_next.rdata[7:0] = s_reg.apD[7:0];
            end else if (wb_adr_i == `PGT_OFS_HIBITS) begin
                s_next.rdata[7:0] = {1'b0, s_reg.apD[8], 1'b0, s_reg.preB[8],
                                     1'b0, s_reg.apC[8], 1'b0, s_reg.preA[8]};
            end else if (wb_adr_i == `PGT_OFS_LIMIT) begin
                s_next.rdata[7:0] = s_reg.limit;
            end else if (wb_adr_i == `PGT_OFS_STATUS) begin
                s_next.rdata[9:0] = {s_reg.running, s_reg.counter};
            end else if (wb_adr_i == `PGT_OFS_OPTS) begin
                s_next.rdata[0] = s_reg.valley;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg       <= '0;
            s_reg.ctrl0 <= `PGT_RST_CTRL0;
            s_reg.ctrl1 <= `PGT_RST_CTRL1;
            s_reg.incr  <= `PGT_RST_INCR;
            s_reg.incFirst <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_dat_o           = s_reg.rdata;
    assign wb_ack_o           = s_reg.ack;
    assign delayed_hw_trigger = s_reg.hwTrig;
    assign pulse_out          = s_reg.pulse;
    assign width_limit_hit    = s_reg.limitHalf;

endmodule // pgt_trigger_ctrl

// *** include/pgt_regs.svh ***
// Purpose: Register offsets, fields, reset values and timing counts of the pulse generator trigger control
// Assumes: Classic Wishbone, 32-bit data, one register per aligned word
// Notes:   Definitions only
`ifndef PGT_REGS_SVH
`define PGT_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define PGT_OFS_CTRL0     8'h00
`define PGT_OFS_CTRL1     8'h04
`define PGT_OFS_INCR      8'h08
`define PGT_OFS_PRA       8'h0C
`define PGT_OFS_PRB       8'h10
`define PGT_OFS_APC       8'h14
`define PGT_OFS_APD       8'h18
`define PGT_OFS_HIBITS    8'h1C
`define PGT_OFS_LIMIT     8'h20
`define PGT_OFS_STATUS    8'h24
`define PGT_OFS_OPTS      8'h28

// ****************************************
// Field positions
// ****************************************
`define PGT_C0_SWTRIG     7
`define PGT_C0_RSTEN      6
`define PGT_C0_STOPEN     5
`define PGT_C0_RELSEL     4
`define PGT_C0_SYNC       3
`define PGT_C0_CNTCLK     2
`define PGT_C0_EDGEMODE   1
`define PGT_C0_ALTREL     0
`define PGT_C1_SRC        7
`define PGT_C1_DLYCLK     6
`define PGT_INC_PERIOD    4
`define PGT_HI_D8         6
`define PGT_HI_B8         4
`define PGT_HI_C8         2
`define PGT_HI_A8         0
`define PGT_OPT_VALLEY    0

// ****************************************
// Reset values and counts
// ****************************************
`define PGT_RST_CTRL0     8'h00
`define PGT_RST_CTRL1     8'h80
`define PGT_RST_INCR      5'h00
`define PGT_INC_UNIMP     3'h7
`define PGT_DELAY_MAX     6'h30
`define PGT_INC_SHORT     5'h08
`define PGT_INC_LONG      5'h10
`define PGT_LIMIT_BASE    9'h100

`endif

// *** include/pgt_pkg.sv ***
// Purpose: Types of the pulse generator trigger control
// Assumes: Used with package-qualified names only
// Notes:   Constants live in pgt_regs.svh
package pgt_pkg;

    typedef enum logic [2:0] {
        RUN_IDLE  = 3'b001,
        RUN_COUNT = 3'b010,
        RUN_DELAY = 3'b100
    } pgt_run_t;

    typedef struct packed {
        logic [7:0]  ctrl0;
        logic [7:0]  ctrl1;
        logic [4:0]  incr;
        logic [8:0]  preA;
        logic [8:0]  preB;
        logic [8:0]  apC;
        logic [8:0]  apD;
        logic [7:0]  limit;
        logic        valley;
        logic [1:0]  pinSync;
        logic [1:0]  c0Sync;
        logic [1:0]  c1Sync;
        logic [1:0]  c2Sync;
        logic [1:0]  c3Sync;
        logic        rawPrev;
        logic        c1Prev;
        logic        c2Prev;
        logic        c3Prev;
        logic        edgeArm;
        logic        dlyActive;
        logic [5:0]  dlyCnt;
        logic        dlyDiv;
        logic        cntDiv;
        logic        running;
        logic [8:0]  counter;
        logic [8:0]  limitCnt;
        logic        limitHalf;
        logic [4:0]  incTimer;
        logic        incFirst;
        logic        hwTrig;
        logic        pulse;
        logic        ack;
        logic [31:0] rdata;
    } pgt_state_t;

endpackage

// *** test/pgt_trigger_ctrl_properties.sv ***
// Purpose: Port-level assertions of the pulse generator trigger control
// Assumes: Ack one cycle after the request edge, pulses one cycle wide
// Notes:   Bound to every instance of the design
`timescale 1ns/1ps
module pgt_trigger_ctrl_props (
    input wire logic        core_clk,           // Clock
    input wire logic        rst_n,              // Reset, active low
    input wire logic        wb_cyc_i,           // Cycle
    input wire logic        wb_stb_i,           // Strobe
    input wire logic        wb_we_i,            // Write enable
    input wire logic [7:0]  wb_adr_i,           // Address
    input wire logic [3:0]  wb_sel_i,           // Byte selects
    input wire logic [31:0] wb_dat_i,           // Write data
    input wire logic [31:0] wb_dat_o,           // Read data
    input wire logic        wb_ack_o,           // Acknowledge
    input wire logic        trigger_input_pin,  // Trigger pin
    input wire logic        comparator0_output, // Comparator 0
    input wire logic        comparator1_event,  // Comparator 1
    input wire logic        comparator2_event,  // Comparator 2
    input wire logic        comparator3_event,  // Comparator 3
    input wire logic        retrigger_active,   // Retrigger pulse
    input wire logic        delayed_hw_trigger, // Delayed trigger
    input wire logic        pulse_out,          // Running level
    input wire logic        width_limit_hit     // Limit pulse
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ****************************************
    // Sequences
    // ****************************************
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_stop_wr;
        (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0] && !wb_dat_i[7])
            ##1 wb_ack_o;
    endsequence
    // ****************************************
    // Assertions
    // ****************************************
    a_ack_follows_req: assert property (s_req |=> wb_ack_o) else $error("ack missing after request");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    a_unmapped_reads_zero: assert property (wb_ack_o && $past(wb_adr_i) > 8'h2B |-> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:10] == 22'h000000) else $error("upper bits set");
    a_sw_stop_ends: assert property (s_stop_wr |-> ##[1:3] !pulse_out) else $error("stop write ignored");
    a_trig_one_cycle: assert property (delayed_hw_trigger |=> !delayed_hw_trigger)
        else $error("delayed trigger too long");
    a_limit_one_cycle: assert property (width_limit_hit |=> !width_limit_hit) else $error("limit pulse too long");
    a_limit_ends_pulse: assert property (width_limit_hit |-> ##[1:2] !pulse_out) else $error("limit kept pulse");
endmodule // pgt_trigger_ctrl_props

bind pgt_trigger_ctrl pgt_trigger_ctrl_props chk_u (.*);

// *** test/pgt_source_model.sv ***
// Purpose: Comparators, trigger pin and retrigger timer in front of the block
// Assumes: Comparator events idle high; their activity is a low phase
// Notes:   Levels change only just after a rising edge
`timescale 1ns/1ps
module pgt_source_model (
    input  wire logic core_clk,           // System clock
    output logic      trigger_input_pin,  // External trigger pin
    output logic      comparator0_output, // Comparator 0 output
    output logic      comparator1_event,  // Comparator 1 event
    output logic      comparator2_event,  // Comparator 2 event
    output logic      comparator3_event,  // Comparator 3 event
    output logic      retrigger_active    // Retrigger activity pulse
);
    logic [5:0] activeMask = 6'h00;
    assign {retrigger_active, comparator3_event, comparator2_event, comparator1_event, comparator0_output,
            trigger_input_pin} = activeMask ^ 6'h1F;
    // Source idx goes active for n cycles; for idx 0 to 4 the return high makes no falling edge
    task automatic drop(input int idx, input int n);
        @(posedge core_clk);
        activeMask[idx] <= 1'b1;
        repeat (n) @(posedge core_clk);
        activeMask[idx] <= 1'b0;
    endtask
endmodule // pgt_source_model

// *** test/pgt_trigger_ctrl_bench.sv ***
// Purpose: Register-level regression of the pulse generator trigger control
// Assumes: Offsets and fields as in pgt_regs.svh
// Notes:   Delay figures are taken relative to the zero-code latency
`timescale 1ns/1ps
`include "pgt_regs.svh"
module pgt_trigger_ctrl_bench;
    logic        core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic        trigger_input_pin, comparator0_output, comparator1_event, comparator2_event, comparator3_event;
    logic        retrigger_active, delayed_hw_trigger, pulse_out, width_limit_hit;
    int          n_errors = 0;
    int          n_compared = 0;
    int          base, t, i, trigs;
    int          nTrig = 0;
    int          codes[3] = '{5, 47, 63};
    pgt_trigger_ctrl dut_u (.*);
    pgt_source_model src_u (.*);
    // Counts delayed trigger pulses, so that a missing or an extra one shows
    always @(posedge core_clk) begin
        if (delayed_hw_trigger === 1'b1) nTrig <= nTrig + 1;
    end
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic print_verdict();
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int k;
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, adr, dat, 4'hF};
        for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++) @(posedge core_clk);
        if (k == 20) begin
            n_errors++;
            print_verdict();
        end
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        wb_cycle(1'b1, adr, dat);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
        wb_cycle(1'b0, adr, 32'h0);
        check(what, exp, rd);
    endtask
    // Counts cycles until pulse_out shows lvl; a hang ends the run
    task automatic wait_out(input logic lvl);
        for (t = 0; t < 600 && pulse_out !== lvl; t++) @(posedge core_clk);
        if (t == 600) begin
            n_errors++;
            print_verdict();
        end
    endtask
    // Pin falls once; t counts cycles until the delayed trigger pulse
    task automatic measure(input logic [7:0] ctrl1Val);
        wr(`PGT_OFS_CTRL1, {24'h00, ctrl1Val});
        fork
            src_u.drop(0, 4);
        join_none
        for (t = 0; t < 300 && delayed_hw_trigger !== 1'b1; t++) @(posedge core_clk);
        if (t == 300) begin
            n_errors++;
            print_verdict();
        end
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        rst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd_chk("ctrl0", `PGT_OFS_CTRL0, 32'h00);
        rd_chk("ctrl1", `PGT_OFS_CTRL1, 32'h80);
        rd_chk("incr", `PGT_OFS_INCR, 32'hE0);
        wr(8'hFC, 32'hFF);
        rd_chk("unmapped", 8'hFC, 32'h00);
        wr(`PGT_OFS_HIBITS, 32'hFF);
        rd_chk("hibits", `PGT_OFS_HIBITS, 32'h55);
        wr(`PGT_OFS_HIBITS, 32'h00);
        measure(8'h00);
        base = t;
        repeat (3) @(posedge core_clk);
        check("no_restart", 1'b0, pulse_out);
        wr(`PGT_OFS_CTRL0, 32'h40);
        measure(8'h00);
        repeat (3) @(posedge core_clk);
        check("hw_restart", 1'b1, pulse_out);
        wr(`PGT_OFS_CTRL0, 32'h40);
        wait_out(1'b0);
        src_u.drop(5, 1);
        repeat (3) @(posedge core_clk);
        check("retrig_restart", 1'b1, pulse_out);
        for (i = 0; i < 3; i++) begin
            repeat (10) @(posedge core_clk);
            measure(codes[i][7:0]);
            check("delay", base + (codes[i] > 48 ? 48 : codes[i]), t);
        end
        measure(8'h45);
        check("half_delay", 1'b1, t >= base + 9 && t <= base + 10);
        repeat (2) @(posedge core_clk);
        trigs = nTrig;
        // A second pin fall lands while the delay still counts
        fork
            begin
                repeat (10) @(posedge core_clk);
                src_u.drop(0, 2);
            end
        join_none
        measure(8'h1E);
        check("busy_delay", base + 30, t);
        repeat (40) @(posedge core_clk);
        check("busy_edge", trigs + 1, nTrig);
        wr(`PGT_OFS_CTRL0, 32'h02);
        trigs = nTrig;
        src_u.drop(0, 4);
        repeat (6) @(posedge core_clk);
        check("double_first", trigs, nTrig);
        measure(8'h00);
        check("double_second", base, t);
        wr(`PGT_OFS_CTRL0, 32'hE0);
        wait_out(1'b1);
        src_u.drop(3, 3);
        repeat (8) @(posedge core_clk);
        check("event_stop", 1'b0, pulse_out);
        rd_chk("stop_flags", `PGT_OFS_CTRL0, 32'h20);
        wr(`PGT_OFS_CTRL0, 32'h80);
        wait_out(1'b1);
        src_u.drop(4, 3);
        repeat (8) @(posedge core_clk);
        check("no_event_stop", 1'b1, pulse_out);
        wr(`PGT_OFS_OPTS, 32'h01);
        wr(`PGT_OFS_CTRL0, 32'hE0);
        src_u.drop(4, 3);
        repeat (8) @(posedge core_clk);
        check("valley_runs", 1'b1, pulse_out);
        rd_chk("valley_keeps", `PGT_OFS_CTRL0, 32'hE0);
        wr(`PGT_OFS_OPTS, 32'h00);
        wr(`PGT_OFS_CTRL0, 32'h01);
        src_u.drop(2, 3);
        repeat (8) @(posedge core_clk);
        rd_chk("alt_reload", `PGT_OFS_CTRL0, 32'h11);
        wr(`PGT_OFS_PRA, 32'h10);
        wr(`PGT_OFS_INCR, 32'h03);
        repeat (40) @(posedge core_clk);
        rd_chk("inc_held", `PGT_OFS_PRA, 32'h10);
        src_u.drop(2, 30);
        repeat (8) @(posedge core_clk);
        // Thirty low cycles: one step at once, then one every 8 clocks, four steps of 3
        rd_chk("inc_step", `PGT_OFS_PRA, 32'h1C);
        base = rd;
        repeat (40) @(posedge core_clk);
        rd_chk("inc_stopped", `PGT_OFS_PRA, base);
        wr(`PGT_OFS_INCR, 32'h00);
        wr(`PGT_OFS_PRA, 32'hF0);
        wr(`PGT_OFS_HIBITS, 32'h01);
        wr(`PGT_OFS_CTRL0, 32'h80);
        wait_out(1'b1);
        wait_out(1'b0);
        check("reload_a", 32'h10, t);
        rd_chk("overflow_clear", `PGT_OFS_CTRL0, 32'h00);
        wr(`PGT_OFS_HIBITS, 32'h00);
        wr(`PGT_OFS_PRA, 32'h00);
        wr(`PGT_OFS_LIMIT, 32'hF0);
        for (i = 0; i < 2; i++) begin
            wr(`PGT_OFS_CTRL0, i ? 32'h84 : 32'h80);
            wait_out(1'b1);
            wait_out(1'b0);
            check("width", 1'b1, t >= (32 << i) - 2 && t <= (32 << i) + 2);
        end
        print_verdict();
    end
endmodule // pgt_trigger_ctrl_bench
